// >>> common/sync_pkg.sv
// constants and bus carriers for the sync classifier and line marker
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus
package sync_pkg;

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SYNC_STATUS = 8'h01;
  localparam logic [7:0] IDX_INPUT_CONFIG = 8'h05;
  localparam logic [7:0] IDX_LINE_POLARITY = 8'h18;
  localparam logic [7:0] IDX_LINE_WIDTH = 8'h19;
  localparam logic [7:0] IDX_POWER = 8'h1B;
  localparam logic [7:0] IDX_SYNC_CLASS = 8'h20;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_HSYNC = 0;
  localparam int ST_VSYNC = 1;
  localparam int ST_SOG = 2;
  localparam int ST_TRILEVEL = 3;
  localparam int ST_COMPOSITE = 4;
  localparam int SRC_LO = 3;
  localparam int SRC_HI = 4;
  localparam int POL_BIT = 7;
  localparam logic [1:0] SRC_SEPARATE = 2'h0;
  localparam logic [1:0] SRC_COMP_H = 2'h1;
  localparam logic [7:0] INPUT_CONFIG_RST = 8'h00;
  localparam logic [7:0] LINE_POLARITY_RST = 8'h80;
  localparam logic [7:0] LINE_WIDTH_RST = 8'h10;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] POWER_STANDBY = 8'h0F;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_SEPARATE,
    CLS_COMP_H,
    CLS_COMP_GREEN,
    CLS_COMP_GREEN_TRI
  } sync_class_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACT_WINDOW_NS = 50_000_000;
  localparam int ACT_WINDOW_CYCLES = ACT_WINDOW_NS / CLK_PERIOD_NS;
  localparam int LONG_PULSE_NS = 15_000;
  localparam int LONG_PULSE_CYCLES =
    (LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOG_RUN = 64;
  localparam int PERIOD_TOL = 2;

endpackage

// >>> logic/sync_classify_line_marker.sv
// sync activity detection, source classification, pass-through sync
// and the line-start pulse for the downstream scaler
// assumes sliced sync inputs are active high and synchronous to clk_in
//
// How it works
// - trilevel flagged without a 64-pulse run
// - composite source selected enables present flag
// - present flag finds broad pulses in hsync, or in green when green selected
// - pass-through sync is unresynchronised buffered copy
// - green selected: whole green stream passes
// - green selected: separated vertical pulse passes
// - protection pulses may stretch or repeat vertical
// - sync paths keep running in standby
// - line pulse ends at pixel 0, pixel-clocked
// - line pulse width is register value pixels
// - line pulse polarity from bit 7
// - wider pulse starts earlier, end fixed
`timescale 1ns/1ns
`default_nettype none

module sync_classify_line_marker #(
  parameter int ACT_WINDOW = sync_pkg::ACT_WINDOW_CYCLES,
  parameter int PIX_W = 12,
  parameter int DATA_W = 24,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire sync_pkg::axi_req_t axi_req_in,
  output sync_pkg::axi_rsp_t axi_rsp_out,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_sync_in,
  input wire logic trilevel_pulse_in,
  input wire logic [PIX_W-1:0] pixel_index_in,
  input wire logic [PIX_W-1:0] line_total_in,
  input wire logic [DATA_W-1:0] pixel_data_in,
  output logic hsync_pass_out,
  output logic vsync_pass_out,
  output logic line_start_pulse_out,
  output logic [DATA_W-1:0] pixel_data_out
);

  localparam int TW = $clog2(ACT_WINDOW + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [TW-1:0] next_timer(input logic hit,
                                               input logic [TW-1:0] t);
    if (hit) begin
      next_timer = TW'(ACT_WINDOW);
    end else if (t != '0) begin
      next_timer = t - TW'(1);
    end else begin
      next_timer = '0;
    end
  endfunction

  function automatic logic near(input logic [CNT_W-1:0] a,
                                input logic [CNT_W-1:0] b);
    logic [CNT_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    near = d <= CNT_W'(sync_pkg::PERIOD_TOL);
  endfunction

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
    bump = (c == '1) ? c : c + CNT_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] input_config;
  logic [7:0] line_polarity;
  logic [7:0] line_pulse_width;
  logic [7:0] power_ctrl;
  logic [7:0] sync_activity_status;
  sync_pkg::sync_class_t sync_class;

  wire [1:0] src_sel = input_config[sync_pkg::SRC_HI:sync_pkg::SRC_LO];
  wire green_sel = src_sel[1];
  wire composite_sel = src_sel != sync_pkg::SRC_SEPARATE;
  wire standby = power_ctrl == sync_pkg::POWER_STANDBY;

  // ----------------------------------------------------------------
  // edge detection on the sliced inputs
  // ----------------------------------------------------------------
  logic hs_prev, vs_prev, gr_prev, tri_prev, sel_prev;
  wire sel_sync = green_sel ? green_sync_in : hsync_in;
  wire hs_rise = hsync_in & ~hs_prev;
  wire vs_rise = vsync_in & ~vs_prev;
  wire gr_rise = green_sync_in & ~gr_prev;
  wire gr_fall = ~green_sync_in & gr_prev;
  wire tri_rise = trilevel_pulse_in & ~tri_prev;
  wire sel_fall = ~sel_sync & sel_prev;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_prev <= 1'b0;
      vs_prev <= 1'b0;
      gr_prev <= 1'b0;
      tri_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      hs_prev <= hsync_in;
      vs_prev <= vsync_in;
      gr_prev <= green_sync_in;
      tri_prev <= trilevel_pulse_in;
      sel_prev <= sel_sync;
    end
  end

  // ----------------------------------------------------------------
  // activity timers, unaffected by standby
  // ----------------------------------------------------------------
  logic [TW-1:0] hs_timer, vs_timer, gr_timer, tri_timer, long_timer;
  logic [CNT_W-1:0] sel_high;
  wire long_seen = sel_fall &&
    sel_high >= CNT_W'(sync_pkg::LONG_PULSE_CYCLES);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_timer <= '0;
      vs_timer <= '0;
      gr_timer <= '0;
      tri_timer <= '0;
      long_timer <= '0;
      sel_high <= '0;
    end else begin
      hs_timer <= next_timer(hs_rise, hs_timer);
      vs_timer <= next_timer(vs_rise, vs_timer);
      gr_timer <= next_timer(gr_rise, gr_timer);
      tri_timer <= next_timer(tri_rise, tri_timer);
      long_timer <= next_timer(long_seen, long_timer);
      sel_high <= sel_sync ? bump(sel_high) : '0;
    end
  end

  // ----------------------------------------------------------------
  // green activity: a run of pulses whose period and width match within PERIOD_TOL
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] gr_count, gr_high, gr_period, gr_width, gr_last_w;
  logic [CNT_W-1:0] line_ref;
  logic [6:0] gr_run;
  logic ext_vsync;
  wire gr_match = near(gr_count, gr_period) && near(gr_width, gr_last_w);
  wire gr_full = gr_run == 7'(sync_pkg::SOG_RUN);
  wire gr_long = green_sync_in &&
    gr_high == CNT_W'(sync_pkg::LONG_PULSE_CYCLES);
  wire gr_line_gap = gr_count >= line_ref - (line_ref >> 2);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gr_count <= '0;
      gr_high <= '0;
      gr_period <= '0;
      gr_width <= '0;
      gr_last_w <= '0;
      gr_run <= '0;
      line_ref <= '0;
      ext_vsync <= 1'b0;
    end else begin
      gr_count <= gr_rise ? CNT_W'(1) : bump(gr_count);
      gr_high <= green_sync_in ? bump(gr_high) : '0;
      if (gr_fall) begin
        gr_width <= gr_high;
      end
      if (gr_rise) begin
        gr_period <= gr_count;
        gr_last_w <= gr_width;
        if (!gr_match) begin
          gr_run <= '0;
        end else if (!gr_full) begin
          gr_run <= gr_run + 7'(1);
        end
        if (!ext_vsync) begin
          line_ref <= gr_count;
        end
      end
      if (gr_long) begin
        ext_vsync <= 1'b1;
      end else if (gr_rise && gr_line_gap) begin
        ext_vsync <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status and classification
  // ----------------------------------------------------------------
  wire hs_act = hs_timer != '0;
  wire vs_act = vs_timer != '0;
  wire gr_act = gr_full && gr_timer != '0;
  wire tri_act = tri_timer != '0;
  wire comp_present = composite_sel && long_timer != '0;
  wire [7:0] next_status = 8'(
    (hs_act << sync_pkg::ST_HSYNC) |
    (vs_act << sync_pkg::ST_VSYNC) |
    (gr_act << sync_pkg::ST_SOG) |
    (tri_act << sync_pkg::ST_TRILEVEL) |
    (comp_present << sync_pkg::ST_COMPOSITE));

  sync_pkg::sync_class_t next_class;
  assign next_class =
    (hs_act && vs_act) ? sync_pkg::CLS_SEPARATE :
    hs_act ? sync_pkg::CLS_COMP_H :
    (gr_act && !tri_act) ? sync_pkg::CLS_COMP_GREEN :
    (gr_act && tri_act) ? sync_pkg::CLS_COMP_GREEN_TRI :
    sync_pkg::CLS_NONE;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_activity_status <= '0;
      sync_class <= sync_pkg::CLS_NONE;
    end else begin
      sync_activity_status <= next_status;
      sync_class <= next_class;
    end
  end

  // ----------------------------------------------------------------
  // pass-through sync, no resynchronisation
  // ----------------------------------------------------------------
  assign hsync_pass_out = green_sel ? green_sync_in : hsync_in;
  assign vsync_pass_out = green_sel ? ext_vsync : vsync_in;

  // ----------------------------------------------------------------
  // line-start pulse, aligned with the registered pixel data
  // ----------------------------------------------------------------
  wire [PIX_W:0] pix_ext = {1'b0, pixel_index_in};
  wire [PIX_W:0] total_ext = {1'b0, line_total_in};
  wire [PIX_W:0] width_ext = (PIX_W + 1)'(line_pulse_width);
  wire lp_window = line_pulse_width != '0 &&
    pix_ext + width_ext >= total_ext && pix_ext < total_ext;
  wire pol_high = line_polarity[sync_pkg::POL_BIT];

  always_ff @(posedge clk_in) begin
    if (srst_in || standby) begin
      line_start_pulse_out <= ~pol_high;
      pixel_data_out <= '0;
    end else begin
      line_start_pulse_out <= lp_window ? pol_high : ~pol_high;
      pixel_data_out <= pixel_data_in;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic aw_held, w_held, bvalid, rvalid;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;

  wire aw_take = axi_req_in.awvalid && !aw_held && !bvalid;
  wire w_take = axi_req_in.wvalid && !w_held && !bvalid;
  wire do_write = aw_held && w_held && !bvalid;
  wire ar_take = axi_req_in.arvalid && !rvalid;

  wire [7:0] a_cfg = {sync_pkg::IDX_INPUT_CONFIG[5:0], 2'b00};
  wire [7:0] a_pol = {sync_pkg::IDX_LINE_POLARITY[5:0], 2'b00};
  wire [7:0] a_wid = {sync_pkg::IDX_LINE_WIDTH[5:0], 2'b00};
  wire [7:0] a_pwr = {sync_pkg::IDX_POWER[5:0], 2'b00};
  wire [7:0] a_sts = {sync_pkg::IDX_SYNC_STATUS[5:0], 2'b00};
  wire [7:0] a_cls = {sync_pkg::IDX_SYNC_CLASS[5:0], 2'b00};

  wire wr_cfg = do_write && w_lane0 && aw_addr == a_cfg;
  wire wr_pol = do_write && w_lane0 && aw_addr == a_pol;
  wire wr_wid = do_write && w_lane0 && aw_addr == a_wid;
  wire wr_pwr = do_write && w_lane0 && aw_addr == a_pwr;
  wire wr_hit = aw_addr == a_cfg || aw_addr == a_pol ||
    aw_addr == a_wid || aw_addr == a_pwr || aw_addr == a_sts ||
    aw_addr == a_cls;

  wire [7:0] ra = axi_req_in.araddr;
  wire rd_hit = ra == a_cfg || ra == a_pol || ra == a_wid ||
    ra == a_pwr || ra == a_sts || ra == a_cls;
  wire [7:0] rd_byte =
    (ra == a_sts) ? sync_activity_status :
    (ra == a_cfg) ? input_config :
    (ra == a_pol) ? line_polarity :
    (ra == a_wid) ? line_pulse_width :
    (ra == a_pwr) ? power_ctrl :
    (ra == a_cls) ? 8'(sync_class) : 8'h00;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= sync_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req_in.awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_byte <= axi_req_in.wdata[7:0];
        w_lane0 <= axi_req_in.wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? sync_pkg::RESP_OKAY : sync_pkg::RESP_SLVERR;
      end else if (bvalid && axi_req_in.bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      input_config <= sync_pkg::INPUT_CONFIG_RST;
      line_polarity <= sync_pkg::LINE_POLARITY_RST;
      line_pulse_width <= sync_pkg::LINE_WIDTH_RST;
      power_ctrl <= sync_pkg::POWER_RST;
    end else begin
      if (wr_cfg) begin
        input_config <= w_byte;
      end
      if (wr_pol) begin
        line_polarity <= w_byte;
      end
      if (wr_wid) begin
        line_pulse_width <= w_byte;
      end
      if (wr_pwr) begin
        power_ctrl <= w_byte;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= sync_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_hit ? sync_pkg::RESP_OKAY : sync_pkg::RESP_SLVERR;
    end else if (rvalid && axi_req_in.rready) begin
      rvalid <= 1'b0;
    end
  end

  assign axi_rsp_out.awready = !aw_held && !bvalid;
  assign axi_rsp_out.wready = !w_held && !bvalid;
  assign axi_rsp_out.bvalid = bvalid;
  assign axi_rsp_out.bresp = bresp;
  assign axi_rsp_out.arready = !rvalid;
  assign axi_rsp_out.rvalid = rvalid;
  assign axi_rsp_out.rdata = rdata;
  assign axi_rsp_out.rresp = rresp;

endmodule

`default_nettype wire

// >>> dv/sync_chk.sv
// port checker for the sync classifier and line marker
// bound to the top module, sees its ports only
`timescale 1ns/1ns
`default_nettype none
module sync_chk #(
  parameter int PIX_W = 12
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire sync_pkg::axi_req_t axi_req_in,
  input wire sync_pkg::axi_rsp_t axi_rsp_out,
  input wire logic hsync_in,
  input wire logic green_sync_in,
  input wire logic [PIX_W-1:0] pixel_index_in,
  input wire logic hsync_pass_out,
  input wire logic line_start_pulse_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic bv = axi_rsp_out.bvalid;
  wire logic rv = axi_rsp_out.rvalid;
  wire logic [PIX_W-1:0] px = pixel_index_in;
  AST_PASS_COPY: assert property (hsync_pass_out == hsync_in ||
    hsync_pass_out == green_sync_in) else $error("pass sync not a copy");
  AST_LINE_IDLE: assert property ($past(px) == 1 && $past(px, 2) == 0 &&
    !$past(bv) && !$past(bv, 2) |-> $stable(line_start_pulse_out))
    else $error("line pulse moved after pixel 0");
  AST_RST_IDLE: assert property ($fell(srst_in) |->
    !line_start_pulse_out) else $error("line pulse active after reset");
  AST_R_ANS: assert property (axi_req_in.arvalid && axi_rsp_out.arready
    |=> rv) else $error("read answer late");
  AST_AR_BLOCK: assert property (rv |-> !axi_rsp_out.arready)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (bv |-> !axi_rsp_out.awready &&
    !axi_rsp_out.wready) else $error("write taken while answer pending");
  AST_B_ANS: assert property (axi_req_in.awvalid && axi_rsp_out.awready &&
    axi_req_in.wvalid && axi_rsp_out.wready |-> ##[1:2] bv)
    else $error("write answer late");
  AST_B_ONCE: assert property (bv && axi_req_in.bready |=> !bv)
    else $error("write answer repeated");
  AST_R_ONCE: assert property (rv && axi_req_in.rready |=> !rv)
    else $error("read answer repeated");
endmodule
bind sync_classify_line_marker sync_chk #(.PIX_W(PIX_W)) u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .axi_req_in(axi_req_in),
  .axi_rsp_out(axi_rsp_out), .hsync_in(hsync_in),
  .green_sync_in(green_sync_in), .pixel_index_in(pixel_index_in),
  .hsync_pass_out(hsync_pass_out),
  .line_start_pulse_out(line_start_pulse_out));
`default_nettype wire

// >>> dv/scaler_model.sv
// scaler model: sends pixel timing and data, checks line start
// assumes line pulse and pixel data are clocked by clk_in
`timescale 1ns/1ns
`default_nettype none
module scaler_model #(
  parameter int TOTAL = 16
) (
  input wire logic clk_in,
  input wire logic pol_in,
  input wire logic line_start_pulse_in,
  input wire logic [23:0] pixel_data_in,
  output logic [11:0] pixel_index_out,
  output logic [23:0] pixel_data_out,
  output logic trail_out,
  output logic trail_ok_out
);
  logic [23:0] pix0 = 24'h000000;
  logic was_act = 1'b0;
  wire logic act = line_start_pulse_in == pol_in;
  initial begin
    pixel_index_out = 12'h000;
    pixel_data_out = 24'h000000;
    trail_out = 1'b0;
    trail_ok_out = 1'b0;
  end
  // pixel stream with fresh data, trailing edge must meet pixel 0
  always @(posedge clk_in) begin
    pixel_index_out <= (pixel_index_out == 12'(TOTAL - 1)) ? 12'h000 :
      pixel_index_out + 12'h001;
    pixel_data_out <= 24'($urandom);
    if (pixel_index_out == 12'h000) pix0 <= pixel_data_out;
    was_act <= act;
    trail_out <= was_act && !act;
    trail_ok_out <= pixel_data_in === pix0;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// bench for the sync classifier and line marker
// assumes package, design, scaler model and checker are compiled
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int TOTAL = 16;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  sync_pkg::axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  sync_pkg::axi_rsp_t rsp;
  logic hs = 1'b0, vs = 1'b0, gs = 1'b0, ts = 1'b0;
  logic hp, vp, lsp, trail, trail_ok;
  logic pol = 1'b1, stby = 1'b0, lchk = 1'b0;
  logic [1:0] lng = 2'h0;
  logic [3:0] pat = 4'h0;
  logic [7:0] wid = 8'h10;
  logic [11:0] pidx, pidx_q;
  logic [23:0] pdat, pdat_q, dout;
  logic [3:0] pats [6] = '{4'h0, 4'hC, 4'h4, 4'hF, 4'h8, 4'h1};
  int ph = 0;
  int error_cnt = 0;
  int tests_run = 0;

  sync_classify_line_marker #(.ACT_WINDOW(2000)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .hsync_in(hs), .vsync_in(vs), .green_sync_in(gs),
    .trilevel_pulse_in(ts), .pixel_index_in(pidx),
    .line_total_in(12'(TOTAL)), .pixel_data_in(pdat),
    .hsync_pass_out(hp), .vsync_pass_out(vp),
    .line_start_pulse_out(lsp), .pixel_data_out(dout));
  scaler_model #(.TOTAL(TOTAL)) u_scaler (.clk_in(clk_in), .pol_in(pol),
    .line_start_pulse_in(lsp), .pixel_data_in(dout),
    .pixel_index_out(pidx), .pixel_data_out(pdat), .trail_out(trail),
    .trail_ok_out(trail_ok));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val,
                    input logic [1:0] er = sync_pkg::RESP_OKAY);
    logic aw, w, b;
    b = 1'b0;
    req.awaddr <= {idx[5:0], 2'h0};
    req.wdata <= {24'h000000, val};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!b) begin
      @(negedge clk_in);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      if (b) chk(32'(rsp.bresp), 32'(er));
      @(posedge clk_in);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp,
                      input logic [1:0] er = sync_pkg::RESP_OKAY);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'b0;
    req.araddr <= {idx[5:0], 2'h0};
    req.arvalid <= 1'b1;
    while (!v) begin
      @(negedge clk_in);
      ar = req.arvalid && rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk_in);
      if (ar) req.arvalid <= 1'b0;
    end
    chk(d, exp);
    chk(32'(r), 32'(er));
  endtask

  // class expected from {trilevel, green, vsync, hsync} activity
  function automatic logic [7:0] cls(input logic [3:0] p);
    if (p[0] && p[1]) return 8'(sync_pkg::CLS_SEPARATE);
    if (p[0]) return 8'(sync_pkg::CLS_COMP_H);
    if (!p[2]) return 8'(sync_pkg::CLS_NONE);
    if (p[3]) return 8'(sync_pkg::CLS_COMP_GREEN_TRI);
    return 8'(sync_pkg::CLS_COMP_GREEN);
  endfunction

  function automatic logic exp_line(input logic [11:0] i);
    return (!stby && wid != 8'h00 && 32'(i) + 32'(wid) >= TOTAL &&
      32'(i) < TOTAL) ? pol : !pol;
  endfunction

  // sync lines: 20-cycle lines, vsync every 200 cycles
  // a nonzero lng holds hsync (bit 0) or green (bit 1) high instead
  always @(posedge clk_in) begin
    ph <= (ph == 199) ? 0 : ph + 1;
    pidx_q <= pidx;
    pdat_q <= pdat;
    hs <= lng[0] || (lng == 2'h0 && pat[0] && ph % 20 < 4);
    vs <= lng == 2'h0 && pat[1] && ph < 4;
    gs <= lng[1] || (lng == 2'h0 && pat[2] && ph % 20 < 4);
    ts <= lng == 2'h0 && pat[3] && ph % 20 == 1;
  end

  always @(negedge clk_in) begin
    if (lchk) begin
      chk(32'(lsp), 32'(exp_line(pidx_q)));
      if (!stby) chk(32'(dout), 32'(pdat_q));
      if (trail) chk(32'(trail_ok), 32'h1);
    end
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(72763));
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    chk(32'(lsp), 32'h0);
    @(posedge clk_in);
    rchk(sync_pkg::IDX_INPUT_CONFIG, 32'(sync_pkg::INPUT_CONFIG_RST));
    rchk(sync_pkg::IDX_LINE_POLARITY, 32'(sync_pkg::LINE_POLARITY_RST));
    rchk(sync_pkg::IDX_LINE_WIDTH, 32'(sync_pkg::LINE_WIDTH_RST));
    rchk(sync_pkg::IDX_POWER, 32'(sync_pkg::POWER_RST));
    rchk(8'h0F, 32'h0, sync_pkg::RESP_SLVERR);
    wr(8'h0F, 8'h5A, sync_pkg::RESP_SLVERR);
    wr(sync_pkg::IDX_SYNC_STATUS, 8'hFF);
    rchk(sync_pkg::IDX_SYNC_STATUS, 32'h00);
    foreach (pats[i]) begin
      pat <= pats[i];
      repeat (200) @(posedge clk_in);
      if (pats[i] == 4'hC) rchk(sync_pkg::IDX_SYNC_STATUS, 32'h08);
      repeat (2400) @(posedge clk_in);
      rchk(sync_pkg::IDX_SYNC_STATUS, {28'h0, pats[i]});
      rchk(sync_pkg::IDX_SYNC_CLASS, {24'h0, cls(pats[i])});
      @(negedge clk_in);
      chk(32'(hp), 32'(hs));
      chk(32'(vp), 32'(vs));
      @(posedge clk_in);
    end
    wr(sync_pkg::IDX_INPUT_CONFIG, 8'h08);
    repeat (10) @(posedge clk_in);
    rchk(sync_pkg::IDX_SYNC_STATUS, 32'h01);
    lng <= 2'h1;
    repeat (800) @(posedge clk_in);
    lng <= 2'h0;
    repeat (10) @(posedge clk_in);
    rchk(sync_pkg::IDX_SYNC_STATUS, 32'h11);
    for (int k = 0; k < 12; k++) begin
      lchk <= 1'b0;
      wid = k == 0 ? 8'h00 : k == 1 ? 8'h01 : k == 2 ? 8'h0E :
        8'($urandom_range(14));
      pol = (k < 2) ? k[0] : 1'($urandom);
      wr(sync_pkg::IDX_LINE_WIDTH, wid);
      wr(sync_pkg::IDX_LINE_POLARITY, {pol, 7'h00});
      rchk(sync_pkg::IDX_LINE_WIDTH, 32'(wid));
      repeat (4) @(posedge clk_in);
      lchk <= 1'b1;
      repeat (3 * TOTAL) @(posedge clk_in);
    end
    wr(sync_pkg::IDX_INPUT_CONFIG, 8'h10);
    pat <= 4'h4;
    repeat (2) begin
      repeat (60) begin
        @(negedge clk_in);
        chk(32'(hp), 32'(gs));
      end
      @(posedge clk_in);
      lchk <= 1'b0;
      wr(sync_pkg::IDX_POWER, sync_pkg::POWER_STANDBY);
      stby = 1'b1;
      repeat (4) @(posedge clk_in);
      lchk <= 1'b1;
    end
    lng <= 2'h2;
    repeat (800) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(vp), 32'h1);
    chk(32'(hp), 32'h1);
    @(posedge clk_in);
    lng <= 2'h0;
    repeat (40) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(vp), 32'h0);
    @(posedge clk_in);
    wrap_up();
  end
endmodule
`default_nettype wire
